/* File: pbd_params.svh */
// Constants for the playback command decoder: offsets, fields, resets, timing
//
// Operation
// - Host stop ends running audio, no auto mute
// - Phrase runs until its stop command
// - Phrase-ending stop lets last audio finish
// - Memory ADPCM playback discards host commands, stalls phrase bytes
// - Stand-by stop mutes, sleeps, wakes on select
// - Set-duration loads milliseconds for later tones
// - Duration zero means endless tone, reset default
// - Expiry starts pending audio or halts tone
// - Tone frequency equals index divided by 4.096
// - Tone index zero gives timed silence
// - Mute ramps down per millisecond, grounds outputs
// - Un-mute enables driver, ramps up per millisecond
// - Play-phrase fetches selected phrase from memory
// - Set-volume picks one of sixteen levels
// - Volume zero silences but keeps driver on
// - Set-outputs bits 7-5 pick mode or levels
// - Reset leaves aux outputs low, push-pull
// - Reset starts muted at full volume
`ifndef PBD_PARAMS_SVH
`define PBD_PARAMS_SVH

// Register offsets (byte addresses)
`define PBD_REG_CMD     8'h00
`define PBD_REG_STATUS  8'h04
`define PBD_REG_CONFIG  8'h08

// Command codes in the low nibble of the first byte
`define PBD_OP_STOP     4'h1
`define PBD_OP_DUR      4'h2
`define PBD_OP_MUTE     4'h4
`define PBD_OP_UNMUTE   4'h5
`define PBD_OP_PHRASE   4'h6
`define PBD_OP_VOLUME   4'h8
`define PBD_OP_OUTPUTS  4'h9
`define PBD_OP_ADPCM    4'ha
`define PBD_OP_PCM      4'he
`define PBD_TONE_LOW2   2'h3

// Field positions
`define PBD_STBY_BIT    4
`define PBD_ACC_MSB     14

// Reset values
`define PBD_VOL_RST     4'hf
`define PBD_DUR_RST     12'h000

// Timing
`define PBD_CLK_NS      5
`define PBD_MS_NS       1000000
`define PBD_SMP_NS      125000
`define PBD_MS_CYCLES   (`PBD_MS_NS / `PBD_CLK_NS)
`define PBD_SMP_CYCLES  (`PBD_SMP_NS / `PBD_CLK_NS)
`define PBD_MS_W        18
`define PBD_SMP_W       15

`endif

/* File: pbd_pkg.sv */
// Types for the playback command decoder
package pbd_pkg;
  `include "pbd_params.svh"

  typedef enum logic {ASM_FIRST, ASM_SECOND} pbd_asm_t;

  typedef struct packed {
    logic                   cs_meta;
    logic                   cs_sync;
    logic                   cs_prev;
    logic                   standby;
    logic                   stby_pend;
    pbd_asm_t               host_asm;
    logic [7:0]             host_byte;
    pbd_asm_t               phr_asm;
    logic [7:0]             phr_byte;
    logic                   phrase_active;
    logic                   phrase_start;
    logic [11:0]            phrase_index;
    logic                   adpcm_busy;
    logic [11:0]            duration;
    logic [11:0]            dur_cnt;
    logic                   tone_on;
    logic                   tone_silent;
    logic [11:0]            tone_index;
    logic [`PBD_SMP_W-1:0]  phase;
    logic [3:0]             volume;
    logic [3:0]             level;
    logic                   mute_req;
    logic                   aux_a;
    logic                   aux_b;
    logic                   aux_od;
    logic [`PBD_MS_W-1:0]   ms_cnt;
    logic [`PBD_SMP_W-1:0]  smp_cnt;
    logic [31:0]            rd_data;
  } pbd_state_t;
endpackage : pbd_pkg

/* File: pbd_decoder.sv */
// Playback command decoder: host and phrase command execution
`timescale 1ns/1ps
`include "pbd_params.svh"
module pbd_decoder #(
  parameter int MS_CYCLES  = `PBD_MS_CYCLES,
  parameter int SMP_CYCLES = `PBD_SMP_CYCLES
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // Host select pin, active low
  input  wire logic        i_host_sel_n,
  // Phrase stream from serial memory
  input  wire logic [7:0]  i_mem_byte,
  input  wire logic        i_mem_valid,
  output logic             o_mem_ready,
  output logic             o_phrase_start,
  output logic [11:0]      o_phrase_index,
  input  wire logic        i_adpcm_done,
  output logic             o_adpcm_busy,
  // Speaker driver
  output logic             o_speaker_out_pos,
  output logic             o_speaker_out_neg,
  output logic             o_spk_enable,
  output logic [3:0]       o_level,
  output logic             o_standby,
  // Auxiliary outputs, enable low while driving
  output logic             o_aux_output_a,
  output logic             o_aux_output_a_oe_n,
  output logic             o_aux_output_b,
  output logic             o_aux_output_b_oe_n
);
  import pbd_pkg::*;

  pbd_state_t st;
  pbd_state_t next_st;
  logic       ms_tick;
  logic       smp_tick;
  logic       cs_fall;
  logic       host_fire;
  logic       mem_fire;
  logic       spk_en;
  logic       sound;

  // True when a first byte opens a two-byte command
  function automatic logic pbd_is16(input logic [7:0] b, input logic phr);
    logic r;
    r = (b[1:0] == `PBD_TONE_LOW2) || (b[3:0] == `PBD_OP_DUR) ||
        (b[3:0] == `PBD_OP_PHRASE) || (b[3:0] == `PBD_OP_PCM) ||
        ((b[3:0] == `PBD_OP_ADPCM) && !phr);
    return r;
  endfunction : pbd_is16

  // Execute one whole command on a state copy
  function automatic pbd_state_t pbd_exec(input pbd_state_t s, input logic [15:0] c,
                                          input logic phr);
    pbd_state_t r;
    r = s;
    if (c[1:0] == `PBD_TONE_LOW2) begin
      r.tone_on = 1'b1;
      r.dur_cnt = s.duration;
      if (c[15:4] == 12'h000) begin
        r.tone_silent = 1'b1;
      end else begin
        r.tone_silent = 1'b0;
        r.tone_index  = c[15:4];
      end
    end else begin
      case (c[3:0])
        `PBD_OP_STOP: begin
          // Host stop cuts audio; phrase stop ends the phrase but leaves the tone running
          if (!phr) begin
            r.tone_on = 1'b0;
          end
          r.phrase_active = 1'b0;
          r.host_asm      = ASM_FIRST;
          r.phr_asm       = ASM_FIRST;
          if (c[`PBD_STBY_BIT]) begin
            r.mute_req  = 1'b1;
            r.stby_pend = 1'b1;
          end
        end
        `PBD_OP_DUR:    r.duration = c[15:4];
        `PBD_OP_MUTE:   r.mute_req = 1'b1;
        `PBD_OP_UNMUTE: r.mute_req = 1'b0;
        `PBD_OP_PHRASE: begin
          // Nested phrase requests are dropped: the stream never resolves
          if (!phr) begin
            r.phrase_active = 1'b1;
            r.phrase_start  = 1'b1;
            r.phrase_index  = c[15:4];
            r.phr_asm       = ASM_FIRST;
            r.tone_on       = 1'b0;
          end
        end
        `PBD_OP_VOLUME: r.volume = c[7:4];
        `PBD_OP_OUTPUTS: begin
          case (c[6:5])
            2'h0:    r.aux_od = c[7];
            2'h1:    r.aux_a  = c[7];
            2'h2:    r.aux_b  = c[7];
            default: begin
              r.aux_a = c[7];
              r.aux_b = c[7];
            end
          endcase
        end
        `PBD_OP_ADPCM: begin
          // From memory the sample stream belongs to the datapath
          if (phr) begin
            r.adpcm_busy = 1'b1;
          end
          r.tone_on = 1'b0;
        end
        `PBD_OP_PCM: r.tone_on = 1'b0;
        default: ;
      endcase
    end
    return r;
  endfunction : pbd_exec

  // Tick strobes and shared decode terms
  assign ms_tick   = (st.ms_cnt == `PBD_MS_W'(MS_CYCLES - 1));
  assign smp_tick  = (st.smp_cnt == `PBD_SMP_W'(SMP_CYCLES - 1));
  assign cs_fall   = st.cs_prev & ~st.cs_sync;
  assign host_fire = i_wr && (i_addr == `PBD_REG_CMD) && !st.adpcm_busy && !st.standby;
  // Phrase intake stalls during a finite tone so the next audio waits
  assign o_mem_ready = st.phrase_active && !st.adpcm_busy && !st.standby &&
                       !(i_wr && (i_addr == `PBD_REG_CMD)) &&
                       !(st.tone_on && (st.duration != 12'h000));
  assign mem_fire  = o_mem_ready && i_mem_valid;

  // Next-state logic
  always_comb begin
    next_st              = st;
    next_st.phrase_start = 1'b0;
    next_st.cs_meta      = i_host_sel_n;
    next_st.cs_sync      = st.cs_meta;
    next_st.cs_prev      = st.cs_sync;
    next_st.ms_cnt       = ms_tick ? '0 : st.ms_cnt + `PBD_MS_W'(1);
    next_st.smp_cnt      = smp_tick ? '0 : st.smp_cnt + `PBD_SMP_W'(1);

    // Read data stands for one cycle only
    next_st.rd_data = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `PBD_REG_STATUS: next_st.rd_data = {23'h000000, st.standby, st.adpcm_busy,
                                            st.phrase_active, st.tone_on, spk_en, st.level};
        `PBD_REG_CONFIG: next_st.rd_data = {4'h0, st.volume, st.duration, st.tone_index};
        default:         next_st.rd_data = 32'h0000_0000;
      endcase
    end

    if (st.standby) begin
      // All but the tick counters, select synchronizer and reads frozen until the host selects the device again
      if (cs_fall) begin
        next_st.standby = 1'b0;
      end
    end else begin
      // Phase accumulator at 8 kHz: f = index * 8000 / 2^15
      if (smp_tick && st.tone_on) begin
        next_st.phase = st.phase + `PBD_SMP_W'(st.tone_index);
      end
      if (ms_tick) begin
        // Finite tone countdown; zero duration never expires
        if (st.tone_on && (st.duration != 12'h000)) begin
          if (st.dur_cnt <= 12'h001) begin
            next_st.tone_on = 1'b0;
          end else begin
            next_st.dur_cnt = st.dur_cnt - 12'h001;
          end
        end
        // One volume step per millisecond toward the target
        if (st.mute_req && (st.level != 4'h0)) begin
          next_st.level = st.level - 4'h1;
        end else if (!st.mute_req && (st.level < st.volume)) begin
          next_st.level = st.level + 4'h1;
        end else if (!st.mute_req && (st.level > st.volume)) begin
          next_st.level = st.level - 4'h1;
        end
      end
      // Sleep only once the mute ramp has reached zero
      if (st.stby_pend && (st.level == 4'h0)) begin
        next_st.standby       = 1'b1;
        next_st.stby_pend     = 1'b0;
        next_st.tone_on       = 1'b0;
        next_st.phrase_active = 1'b0;
      end
      if (st.adpcm_busy && i_adpcm_done) begin
        next_st.adpcm_busy = 1'b0;
      end

      // Host bytes win the cycle over phrase bytes
      if (host_fire) begin
        if (st.host_asm == ASM_FIRST) begin
          if (pbd_is16(i_wdata[7:0], 1'b0)) begin
            next_st.host_asm  = ASM_SECOND;
            next_st.host_byte = i_wdata[7:0];
          end else begin
            next_st = pbd_exec(next_st, {8'h00, i_wdata[7:0]}, 1'b0);
          end
        end else begin
          next_st.host_asm = ASM_FIRST;
          next_st = pbd_exec(next_st, {i_wdata[7:0], st.host_byte}, 1'b0);
        end
      end else if (mem_fire) begin
        case (st.phr_asm)
          ASM_FIRST: begin
            if (pbd_is16(i_mem_byte, 1'b1)) begin
              next_st.phr_asm  = ASM_SECOND;
              next_st.phr_byte = i_mem_byte;
            end else begin
              next_st = pbd_exec(next_st, {8'h00, i_mem_byte}, 1'b1);
            end
          end
          ASM_SECOND: begin
            next_st.phr_asm = ASM_FIRST;
            next_st = pbd_exec(next_st, {i_mem_byte, st.phr_byte}, 1'b1);
          end
          default: next_st.phr_asm = ASM_FIRST;
        endcase
      end
    end
  end

  // State register; resets to muted, full volume, aux low push-pull
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st            <= '0;
      st.cs_meta    <= 1'b1;
      st.cs_sync    <= 1'b1;
      st.cs_prev    <= 1'b1;
      st.host_asm   <= ASM_FIRST;
      st.phr_asm    <= ASM_FIRST;
      st.duration   <= `PBD_DUR_RST;
      st.volume     <= `PBD_VOL_RST;
      st.mute_req   <= 1'b1;
      st.aux_od     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; a muted driver at level zero ties both pins low
  assign spk_en  = !st.mute_req || (st.level != 4'h0);
  assign sound   = spk_en && st.tone_on && !st.tone_silent && (st.level != 4'h0);
  assign o_speaker_out_pos   = sound & st.phase[`PBD_ACC_MSB];
  assign o_speaker_out_neg   = sound & ~st.phase[`PBD_ACC_MSB];
  assign o_spk_enable        = spk_en;
  assign o_level             = st.level;
  assign o_standby           = st.standby;
  assign o_rdata             = st.rd_data;
  assign o_phrase_start      = st.phrase_start;
  assign o_phrase_index      = st.phrase_index;
  assign o_adpcm_busy        = st.adpcm_busy;
  // Open drain only ever drives low; a high level releases the pin
  assign o_aux_output_a      = st.aux_od ? 1'b0 : st.aux_a;
  assign o_aux_output_a_oe_n = st.aux_od ? st.aux_a : 1'b0;
  assign o_aux_output_b      = st.aux_od ? 1'b0 : st.aux_b;
  assign o_aux_output_b_oe_n = st.aux_od ? st.aux_b : 1'b0;

  // Checks
  host_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (host_fire && st.host_asm == ASM_FIRST && i_wdata[3:0] == `PBD_OP_STOP)
    |=> !st.tone_on && ($past(st.mute_req) == st.mute_req || st.stby_pend))
    else $error("host stop left tone running");
  adpcm_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.adpcm_busy && !i_adpcm_done) |=> st.adpcm_busy && $stable(st.duration)
    && $stable(st.volume))
    else $error("command taken during memory playback");
  stby_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(st.standby) |-> st.level == 4'h0 && st.mute_req && !st.tone_on)
    else $error("stand-by entered without mute");
  dur_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(st.tone_on) |-> st.dur_cnt == st.duration)
    else $error("tone started without duration");
  endless_tone_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.tone_on && st.duration == 12'h000 && !i_wr && !mem_fire && !st.stby_pend
     && !st.standby) |=> st.tone_on)
    else $error("endless tone stopped");
  tone_expire_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.tone_on && st.duration != 12'h000 && st.dur_cnt == 12'h001 && ms_tick
     && !st.standby && !host_fire) |=> !st.tone_on)
    else $error("finite tone did not expire");
  phrase_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.tone_on && st.duration != 12'h000) |-> !o_mem_ready)
    else $error("phrase advanced during finite tone");
  silent_tone_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.tone_silent |-> !o_speaker_out_pos && !o_speaker_out_neg)
    else $error("silent tone drives speaker");
  ramp_rate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ms_tick |=> $stable(st.level))
    else $error("level moved between millisecond ticks");
  mute_ground_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_spk_enable |-> !o_speaker_out_pos && !o_speaker_out_neg && o_level == 4'h0)
    else $error("muted driver not grounded");
  vol_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!st.mute_req && st.volume == 4'h0) |-> o_spk_enable)
    else $error("volume zero disabled driver");
  // Command effects seen one cycle after the completing host byte
  vol_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (host_fire && st.host_asm == ASM_FIRST && i_wdata[3:0] == `PBD_OP_VOLUME)
    |=> st.volume == $past(i_wdata[7:4]))
    else $error("volume not loaded");
  dur_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (host_fire && st.host_asm == ASM_SECOND && st.host_byte[3:0] == `PBD_OP_DUR)
    |=> st.duration == $past({i_wdata[7:0], st.host_byte[7:4]}))
    else $error("duration not loaded");
  phrase_go_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (host_fire && st.host_asm == ASM_SECOND && st.host_byte[3:0] == `PBD_OP_PHRASE)
    |=> st.phrase_active && o_phrase_start && o_phrase_index == $past({i_wdata[7:0], st.host_byte[7:4]}))
    else $error("phrase request not issued");
  // Ramp steps exactly one level per millisecond tick
  mute_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.mute_req && ms_tick && st.level != 4'h0 && !st.standby)
    |=> st.level == $past(st.level) - 4'h1)
    else $error("mute ramp step wrong");
  unmute_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!st.mute_req && ms_tick && st.level < st.volume && !st.standby)
    |=> st.level == $past(st.level) + 4'h1)
    else $error("un-mute ramp step wrong");
  stby_wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.standby && cs_fall) |=> !st.standby)
    else $error("select did not wake device");
  aux_push_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !st.aux_od |-> !o_aux_output_a_oe_n && !o_aux_output_b_oe_n)
    else $error("push-pull aux not driven");

endmodule : pbd_decoder

/* File: pbd_mem_model.sv */
// Serial memory phrase stream model for the playback command decoder
`timescale 1ns/1ps
module pbd_mem_model (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Phrase request from the decoder
  input  wire logic        i_phrase_start,
  input  wire logic [11:0] i_phrase_index,
  input  wire logic        i_slow,
  // Byte stream towards the decoder
  input  wire logic        i_mem_ready,
  output logic [7:0]       o_mem_byte,
  output logic             o_mem_valid
);
  logic [7:0] q[$];
  logic       gap;

  // Byte held until taken; idle line flips so stale data never looks valid
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q.delete();
      gap <= 1'b0;
      o_mem_valid <= 1'b0;
      o_mem_byte <= 8'h00;
    end else begin
      if (o_mem_valid && i_mem_ready) begin
        void'(q.pop_front());
      end
      // Phrases hold no play-phrase byte and always end on a stop byte
      if (i_phrase_start) begin
        case (i_phrase_index)
          12'h101: q = '{8'h38, 8'h01};
          12'h202: q = '{8'h0a, 8'h01};
          12'h303: q = '{8'h22, 8'h00, 8'h03, 8'h80, 8'h01};
          default: q = '{8'h01};
        endcase
      end
      // Slow mode leaves one idle cycle after each byte taken
      gap <= i_slow && o_mem_valid && i_mem_ready;
      o_mem_valid <= (q.size() > 0) && !(i_slow && o_mem_valid && i_mem_ready);
      o_mem_byte <= (q.size() > 0) ? q[0] : ~o_mem_byte;
    end
  end
endmodule : pbd_mem_model

/* File: pbd_decoder_tb_top.sv */
// Self-checking bench for the playback command decoder
`timescale 1ns/1ps
module pbd_decoder_tb_top;
  localparam int MS = 20;
  // Design connections
  logic        i_sys_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_host_sel_n = 1;
  logic        i_adpcm_done = 0, i_mem_valid, o_mem_ready, o_phrase_start, o_adpcm_busy;
  logic [7:0]  i_addr = 0, i_mem_byte;
  logic [31:0] i_wdata = 0, o_rdata, rd_val, seed = 32'h7d09db51;
  logic [11:0] o_phrase_index;
  logic        o_speaker_out_pos, o_speaker_out_neg, o_spk_enable, o_standby;
  logic [3:0]  o_level;
  logic        o_aux_output_a, o_aux_output_a_oe_n, o_aux_output_b, o_aux_output_b_oe_n;
  logic        slow = 0, pa, a, b, od;
  logic [2:0]  cfg;
  logic [2:0]  codes [5] = '{3'b111, 3'b100, 3'b001, 3'b000, 3'b010};
  int          miscompares = 0, checked = 0, cycles = 0, vol, dur, n, k;

  pbd_decoder #(.MS_CYCLES(MS), .SMP_CYCLES(4)) uut (.i_sys_clk, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_host_sel_n, .i_mem_byte, .i_mem_valid,
    .o_mem_ready, .o_phrase_start, .o_phrase_index, .i_adpcm_done, .o_adpcm_busy,
    .o_speaker_out_pos, .o_speaker_out_neg, .o_spk_enable, .o_level, .o_standby,
    .o_aux_output_a, .o_aux_output_a_oe_n, .o_aux_output_b, .o_aux_output_b_oe_n);

  pbd_mem_model mem (.i_sys_clk, .i_rst_n, .i_phrase_start(o_phrase_start),
    .i_phrase_index(o_phrase_index), .i_slow(slow), .i_mem_ready(o_mem_ready),
    .o_mem_byte(i_mem_byte), .o_mem_valid(i_mem_valid));

  // 200 MHz system clock
  always #2.5 i_sys_clk = ~i_sys_clk;

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Register port cycles, strobes one cycle long
  task automatic wr(input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= 8'h00;
    i_wdata <= {24'h0, d};
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic wr16(input logic [15:0] c);
    wr(c[7:0]);
    wr(c[15:8]);
  endtask : wr16

  task automatic rd(input logic [7:0] ad);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd

  task automatic cyc(input int c);
    repeat (c) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  task automatic tally_and_finish();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    cyc(1);
    // Reset state: aux low push-pull, muted, full volume, endless duration
    chk({o_aux_output_a, o_aux_output_a_oe_n, o_aux_output_b, o_aux_output_b_oe_n}, 0);
    chk({o_standby, o_spk_enable, o_level}, 0);
    vol = 15;
    dur = 0;
    rd(8'h08);
    chk(rd_val[27:12], {vol[3:0], dur[11:0]});
    $display("test reset done");
    // Random volume levels
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      vol = seed[3:0];
      wr({seed[3:0], 4'h8});
      rd(8'h08);
      chk(rd_val[27:24], vol[3:0]);
    end
    // Un-mute ramps to the set level; zero volume keeps driver on
    wr(8'h05);
    cyc(17 * MS);
    chk({o_spk_enable, o_level}, {1'b1, vol[3:0]});
    wr(8'h08);
    cyc(17 * MS);
    chk({o_spk_enable, o_level}, 5'h10);
    wr(8'hf8);
    vol = 15;
    cyc(17 * MS);
    chk(o_level, vol);
    $display("test volume done");
    // Finite tone ends after its duration
    dur = 2;
    wr16({dur[11:0], 4'h2});
    rd(8'h08);
    chk(rd_val[23:12], dur);
    wr16(16'h1003);
    rd(8'h04);
    chk(rd_val[5], 1);
    cyc((dur + 1) * MS + 5);
    rd(8'h04);
    chk({rd_val[5], o_speaker_out_pos, o_speaker_out_neg}, 0);
    // Endless tone: count speaker toggles over 256 cycles
    dur = 0;
    wr16(16'h0002);
    wr16(16'h8003);
    cyc(2);
    k = 0;
    pa = o_speaker_out_pos;
    repeat (256) begin
      cyc(1);
      if (o_speaker_out_pos !== pa) k++;
      pa = o_speaker_out_pos;
    end
    chk(k, 256 * 2048 / (4 * 16384));
    // Index zero keeps the tone running but silent
    wr16(16'h0003);
    cyc(100);
    rd(8'h04);
    chk({rd_val[5], o_speaker_out_pos, o_speaker_out_neg}, 3'b100);
    // Host stop ends the tone without muting
    wr(8'h01);
    rd(8'h04);
    chk(rd_val[5:0], {1'b0, 1'b1, vol[3:0]});
    $display("test tone done");
    // Aux output settings through five of the eight bit 7-5 patterns
    a = 0;
    b = 0;
    od = 0;
    for (n = 0; n < 5; n++) begin
      cfg = codes[n];
      wr({cfg, 5'h09});
      case (cfg[1:0])
        2'd0: od = cfg[2];
        2'd1: a = cfg[2];
        2'd2: b = cfg[2];
        default: begin
          a = cfg[2];
          b = cfg[2];
        end
      endcase
      cyc(1);
      chk({o_aux_output_a, o_aux_output_a_oe_n, o_aux_output_b, o_aux_output_b_oe_n},
          od ? {1'b0, a, 1'b0, b} : {a, 1'b0, b, 1'b0});
    end
    $display("test outputs done");
    // Phrase sets volume, then ends on its stop byte
    wr16({12'h101, 4'h6});
    for (n = 0; n < 8 && o_phrase_start !== 1'b1; n++) cyc(1);
    chk({o_phrase_start, o_phrase_index}, {1'b1, 12'h101});
    vol = 3;
    cyc(20);
    rd(8'h08);
    chk(rd_val[27:24], vol);
    rd(8'h04);
    chk(rd_val[6], 0);
    // Memory ADPCM ignores volume and stop until done
    wr16({12'h202, 4'h6});
    cyc(10);
    chk(o_adpcm_busy, 1);
    wr(8'hf8);
    wr(8'h01);
    cyc(5);
    chk(o_adpcm_busy, 1);
    i_adpcm_done <= 1'b1;
    @(posedge i_sys_clk);
    i_adpcm_done <= 1'b0;
    cyc(10);
    rd(8'h08);
    chk(rd_val[27:24], vol);
    rd(8'h04);
    chk(rd_val[7:6], 0);
    // Slow phrase: its last tone runs out before the phrase ends
    slow = 1;
    wr16({12'h303, 4'h6});
    cyc(15);
    rd(8'h04);
    chk(rd_val[6:5], 2'b11);
    cyc(3 * MS);
    rd(8'h04);
    chk(rd_val[6:5], 0);
    $display("test phrase done");
    // Mute ramps down and grounds the speaker
    wr(8'h04);
    cyc(17 * MS);
    chk({o_spk_enable, o_level, o_speaker_out_pos, o_speaker_out_neg}, 0);
    // Stand-by mutes first, refuses writes, wakes on select
    wr(8'h05);
    cyc(5 * MS);
    wr(8'h11);
    cyc(6 * MS);
    chk({o_standby, o_spk_enable, o_level}, 6'h20);
    wr(8'h78);
    i_host_sel_n <= 1'b0;
    cyc(100);
    chk(o_standby, 0);
    i_host_sel_n <= 1'b1;
    rd(8'h08);
    chk(rd_val[27:24], vol);
    $display("test standby done");
    tally_and_finish();
  end
endmodule : pbd_decoder_tb_top
